// ---- core/haptic_event_diagnostics.sv ----
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module haptic_event_diagnostics (
    input  wire logic                               ref_clk_in,
    input  wire logic                               sys_rst_in,
    input  wire logic                               psel_in,
    input  wire logic                               penable_in,
    input  wire logic                               pwrite_in,
    input  wire logic [haptic_diag_pkg::ADDR_W-1:0] paddr_in,
    input  wire logic [haptic_diag_pkg::DATA_W-1:0] pwdata_in,
    output logic      [haptic_diag_pkg::DATA_W-1:0] prdata_out,
    output logic                                    pready_out,
    output logic                                    pslverr_out,
    input  wire logic                               overcurrent_in,
    input  wire logic                               impedance_bad_in,
    input  wire logic                               bemf_bad_in,
    input  wire logic [haptic_diag_pkg::FREQ_W-1:0] freq_hz_in,
    input  wire logic                               freq_valid_in,
    input  wire logic                               overheat_in,
    input  wire logic                               undervoltage_in,
    input  wire logic                               seq_done_in,
    input  wire logic                               seq_restart_in,
    input  wire logic                               adc_saturated_in,
    input  wire logic                               drive_limited_in,
    input  wire logic                               accel_limited_in,
    input  wire logic                               mem_type_bad_in,
    input  wire logic                               missing_sequence_in,
    input  wire logic                               mem_corrupt_in,
    input  wire logic                               pwm_timeout_in,
    input  wire logic                               play_request_in,
    input  wire logic                               play_stop_in,
    input  wire logic                               host_alert_n_in,
    output logic                                    host_alert_n_out,
    output logic                                    host_alert_n_oe_n_out,
    output logic                                    playback_active_out,
    output logic                                    playback_refused_out,
    output logic                                    repeat_request_out
);
    // Flag carriers between this module and the banks
    flag_bus_if #(.W(haptic_diag_pkg::FAULT_W)) fault_fb ();
    flag_bus_if #(.W(haptic_diag_pkg::NOTE_W))  note_fb ();
    flag_bus_if #(.W(haptic_diag_pkg::WARN_W))  warn_fb ();
    flag_bus_if #(.W(haptic_diag_pkg::INFLT_W)) inflt_fb ();

    // Software state
    logic [haptic_diag_pkg::FAULT_W-1:0] mask_a_ff;   // Fault mask
    logic [haptic_diag_pkg::NOTE_W-1:0]  mask_b_ff;   // Notification mask
    logic [haptic_diag_pkg::CTRL_W-1:0]  ctrl_ff;     // Bypass and repeat
    logic [haptic_diag_pkg::CTRL_W-1:0]  nxt_ctrl;    // Next control
    // Bus answer registers
    logic [haptic_diag_pkg::DATA_W-1:0]  prdata_ff;   // Read data
    logic                                pready_ff;   // Access done
    logic                                pslverr_ff;  // Unmapped access
    // Playback and alert state
    haptic_diag_pkg::play_state_t        state_ff;    // Playback state
    haptic_diag_pkg::play_state_t        nxt_state;   // Next state
    logic                                active_ff;   // Driving output
    logic                                refused_ff;  // Refusal pulse
    logic                                alert_ff;    // Alert asserted
    logic                                pin_lvl_ff;  // Driven pin level
    logic [haptic_diag_pkg::DATA_W-1:0]  rd_mux;      // Read selection
    logic                                freq_bad;    // Range check pulse

    // Address decode
    wire hit_fault  = paddr_in == haptic_diag_pkg::OFS_FAULT;
    wire hit_note   = paddr_in == haptic_diag_pkg::OFS_NOTE;
    wire hit_warn   = paddr_in == haptic_diag_pkg::OFS_WARN;
    wire hit_inflt  = paddr_in == haptic_diag_pkg::OFS_INFLT;
    wire hit_mask_a = paddr_in == haptic_diag_pkg::OFS_MASK_A;
    wire hit_mask_b = paddr_in == haptic_diag_pkg::OFS_MASK_B;
    wire hit_ctrl   = paddr_in == haptic_diag_pkg::OFS_CTRL;
    wire hit_stat   = paddr_in == haptic_diag_pkg::OFS_STAT;
    wire addr_hit   = hit_fault | hit_note | hit_warn | hit_inflt |
                      hit_mask_a | hit_mask_b | hit_ctrl | hit_stat;

    // Bus phases; writes land only on the completing edge
    wire access   = psel_in & penable_in;
    wire answer   = access & ~pready_ff;
    wire wr_take  = access & pready_ff & pwrite_in;
    wire wr_fault = wr_take & hit_fault;
    wire wr_note  = wr_take & hit_note;
    wire wr_warn  = wr_take & hit_warn;
    wire wr_inflt = wr_take & hit_inflt;

    // Control bits
    wire bypass     = ctrl_ff[haptic_diag_pkg::CB_BYPASS];
    wire repeat_req = ctrl_ff[haptic_diag_pkg::CB_REPEAT];
    wire repeat_hit = seq_restart_in & repeat_req & active_ff;

    // Flag groups seen by the rest of the logic
    wire [haptic_diag_pkg::FAULT_W-1:0] fault_flags = fault_fb.flags;
    wire [haptic_diag_pkg::NOTE_W-1:0]  note_flags  = note_fb.flags;
    wire [haptic_diag_pkg::WARN_W-1:0]  warn_flags  = warn_fb.flags;
    wire [haptic_diag_pkg::INFLT_W-1:0] inflt_flags = inflt_fb.flags;
    wire [haptic_diag_pkg::INFLT_W-1:0] inflt_evt;
    wire input_fault_evt = |inflt_evt;

    // Input data faults
    assign inflt_evt[haptic_diag_pkg::IB_MISSING] = missing_sequence_in;
    assign inflt_evt[haptic_diag_pkg::IB_MEM]     = mem_corrupt_in;
    assign inflt_evt[haptic_diag_pkg::IB_PWM]     = pwm_timeout_in;
    assign inflt_fb.set_evt = inflt_evt;
    // Clearing the summary sequence flag also drops the PWM detail
    assign inflt_fb.clr_req = (wr_inflt ? pwdata_in[2:0] : 3'h0) |
        {(wr_fault & pwdata_in[haptic_diag_pkg::FB_SEQ_PROBLEM]),
         2'h0};

    // Fault summary byte
    assign fault_fb.set_evt[haptic_diag_pkg::FB_OVERCURRENT] =
        overcurrent_in;
    assign fault_fb.set_evt[haptic_diag_pkg::FB_ACTUATOR] =
        impedance_bad_in | bemf_bad_in | freq_bad;
    assign fault_fb.set_evt[haptic_diag_pkg::FB_SEQ_PROBLEM] =
        input_fault_evt;
    assign fault_fb.set_evt[haptic_diag_pkg::FB_OVERHEAT]  = overheat_in;
    assign fault_fb.set_evt[haptic_diag_pkg::FB_UNDERVOLT] = undervoltage_in;
    assign fault_fb.clr_req =
        wr_fault ? pwdata_in[4:0] : 5'h00;

    // Notifications; warning summary re-sets while any warning stands
    assign note_fb.set_evt[haptic_diag_pkg::NB_DONE]    = seq_done_in;
    assign note_fb.set_evt[haptic_diag_pkg::NB_REPEAT]  = repeat_hit;
    assign note_fb.set_evt[haptic_diag_pkg::NB_WARNING] = |warn_flags;
    assign note_fb.set_evt[haptic_diag_pkg::NB_ADC_SAT] =
        adc_saturated_in;
    assign note_fb.clr_req = wr_note ? pwdata_in[3:0] : 4'h0;

    // Warning detail
    assign warn_fb.set_evt[haptic_diag_pkg::WB_DRIVE]    = drive_limited_in;
    assign warn_fb.set_evt[haptic_diag_pkg::WB_ACCEL]    = accel_limited_in;
    assign warn_fb.set_evt[haptic_diag_pkg::WB_MEM_TYPE] = mem_type_bad_in;
    assign warn_fb.clr_req = wr_warn ? pwdata_in[2:0] : 3'h0;

    // Sticky flag banks
    flag_bank #(.W(haptic_diag_pkg::FAULT_W)) u_fault_bank (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .fb         (fault_fb.bank)
    );
    flag_bank #(.W(haptic_diag_pkg::NOTE_W)) u_note_bank (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .fb         (note_fb.bank)
    );
    flag_bank #(.W(haptic_diag_pkg::WARN_W)) u_warn_bank (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .fb         (warn_fb.bank)
    );
    flag_bank #(.W(haptic_diag_pkg::INFLT_W)) u_inflt_bank (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .fb         (inflt_fb.bank)
    );

    // Resonant frequency window check
    freq_range_check u_freq_check (
        .ref_clk_in       (ref_clk_in),
        .sys_rst_in       (sys_rst_in),
        .freq_hz_in       (freq_hz_in),
        .freq_valid_in    (freq_valid_in),
        .bypass_in        (bypass),
        .out_of_range_out (freq_bad)
    );

    // Playback gating: a fault in flight counts as well as a stored one
    wire fault_any   = |fault_flags;
    wire fault_now   = |fault_fb.set_evt;
    wire fault_block = fault_any | fault_now;
    wire start_ok    = play_request_in & ~fault_block;
    wire refuse      = play_request_in & fault_block &
                       (state_ff == haptic_diag_pkg::ST_IDLE);

    // Next playback state; warnings play no part here
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            haptic_diag_pkg::ST_IDLE: begin
                if (start_ok) begin
                    nxt_state = haptic_diag_pkg::ST_DRIVE;
                end
            end
            haptic_diag_pkg::ST_DRIVE: begin
                // Fault, stop or end of sequence fall back to idle
                if (fault_block | play_stop_in | seq_done_in) begin
                    nxt_state = haptic_diag_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = haptic_diag_pkg::ST_IDLE;
            end
        endcase
    end

    // Playback registers
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_ff   <= haptic_diag_pkg::ST_IDLE;
            active_ff  <= 1'b0;
            refused_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            active_ff  <= nxt_state == haptic_diag_pkg::ST_DRIVE;
            refused_ff <= refuse;
        end
    end

    // Unmasked pending flags drive the alert
    wire pend_a = |(fault_flags & ~mask_a_ff);
    wire pend_b = |(note_flags & ~mask_b_ff);

    // Alert line; the pin is only ever pulled low, never driven high
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            alert_ff   <= 1'b0;
            pin_lvl_ff <= 1'b0;
        end else begin
            alert_ff   <= pend_a | pend_b;
            pin_lvl_ff <= 1'b0;
        end
    end

    // Control: software write wins, a taken repeat consumes the request
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_take & hit_ctrl) begin
            nxt_ctrl = pwdata_in[1:0];
        end else if (repeat_hit) begin
            nxt_ctrl[haptic_diag_pkg::CB_REPEAT] = 1'b0;
        end
    end

    // Mask and control registers
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            mask_a_ff <= haptic_diag_pkg::MASK_A_RST;
            mask_b_ff <= haptic_diag_pkg::MASK_B_RST;
            ctrl_ff   <= haptic_diag_pkg::CTRL_RST;
        end else begin
            if (wr_take & hit_mask_a) begin
                mask_a_ff <= pwdata_in[4:0];
            end
            if (wr_take & hit_mask_b) begin
                mask_b_ff <= pwdata_in[3:0];
            end
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Read selection, narrow registers zero-extended
    always_comb begin
        rd_mux = '0;
        if (hit_fault) begin
            rd_mux[4:0] = fault_flags;
        end else if (hit_note) begin
            rd_mux[3:0] = note_flags;
        end else if (hit_warn) begin
            rd_mux[2:0] = warn_flags;
        end else if (hit_inflt) begin
            rd_mux[2:0] = inflt_flags;
        end else if (hit_mask_a) begin
            rd_mux[4:0] = mask_a_ff;
        end else if (hit_mask_b) begin
            rd_mux[3:0] = mask_b_ff;
        end else if (hit_ctrl) begin
            rd_mux[1:0] = ctrl_ff;
        end else if (hit_stat) begin
            rd_mux[haptic_diag_pkg::SB_ACTIVE] = active_ff;
            rd_mux[haptic_diag_pkg::SB_ALERT]  = alert_ff;
            rd_mux[haptic_diag_pkg::SB_PIN]    = host_alert_n_in;
        end
    end

    // Bus answer: one wait state, data and error latched together
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end else begin
            pready_ff  <= answer;
            pslverr_ff <= answer & ~addr_hit;
            if (answer) begin
                prdata_ff <= pwrite_in ? '0 : rd_mux;
            end
        end
    end

    // Outputs, all from flops
    assign prdata_out            = prdata_ff;
    assign pready_out            = pready_ff;
    assign pslverr_out           = pslverr_ff;
    assign host_alert_n_out      = pin_lvl_ff;
    assign host_alert_n_oe_n_out = ~alert_ff;
    assign playback_active_out   = active_ff;
    assign playback_refused_out  = refused_ff;
    assign repeat_request_out    = repeat_req;

    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    fault_forces_idle_a: assert property (
        fault_any |=> !active_ff && !playback_active_out)
        else $error("Playback active with fault pending");
    warn_keeps_play_a: assert property (
        active_ff && !fault_block && !play_stop_in && !seq_done_in
        |=> active_ff)
        else $error("Playback dropped without fault or stop");
    alert_follows_a: assert property (
        (pend_a || pend_b) |=> !host_alert_n_oe_n_out)
        else $error("Alert not pulled for pending event");
    masked_quiet_a: assert property (
        (fault_flags == mask_a_ff) && (note_flags == '0) &&
        $stable(mask_a_ff) |=> host_alert_n_oe_n_out)
        else $error("Masked flag pulled alert");
    overcurrent_set_a: assert property (
        overcurrent_in |=> fault_flags[haptic_diag_pkg::FB_OVERCURRENT])
        else $error("Over-current flag not set");
    clear_one_a: assert property (
        wr_fault && pwdata_in[0] && !overcurrent_in
        |=> !fault_flags[haptic_diag_pkg::FB_OVERCURRENT])
        else $error("Write one did not clear flag");
    freq_fault_a: assert property (
        freq_valid_in && !bypass && (freq_hz_in > haptic_diag_pkg::FREQ_MAX_HZ)
        |=> ##1 fault_flags[haptic_diag_pkg::FB_ACTUATOR])
        else $error("Out of range frequency not faulted");
    bypass_quiet_a: assert property (
        freq_valid_in && bypass |=> !freq_bad)
        else $error("Bypassed range check raised fault");
    seq_summary_a: assert property (
        missing_sequence_in |=> fault_flags[haptic_diag_pkg::FB_SEQ_PROBLEM]
        && inflt_flags[haptic_diag_pkg::IB_MISSING])
        else $error("Input fault not summarised");
    warn_note_a: assert property (
        drive_limited_in |=> ##1 note_flags[haptic_diag_pkg::NB_WARNING])
        else $error("Warning notification missing");
    apb_answer_a: assert property (
        access && !pready_ff |=> pready_ff ##1 !pready_ff)
        else $error("APB answer timing wrong");

    cover_refuse: cover property (refused_ff);
    cover_play_done: cover property (active_ff ##1 seq_done_in ##1 !active_ff);
    cover_repeat: cover property (repeat_hit);
    cover_bad_addr: cover property (pslverr_ff);
endmodule

// ---- include/haptic_diag_pkg.sv ----
package haptic_diag_pkg;
    // Bus geometry
    localparam int ADDR_W = 8;                      // Byte address width
    localparam int DATA_W = 32;                     // APB data width

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_FAULT  = 8'h00; // Fault summary
    localparam logic [ADDR_W-1:0] OFS_NOTE   = 8'h04; // Notifications
    localparam logic [ADDR_W-1:0] OFS_WARN   = 8'h08; // Warning detail
    localparam logic [ADDR_W-1:0] OFS_INFLT  = 8'h0c; // Input fault detail
    localparam logic [ADDR_W-1:0] OFS_MASK_A = 8'h10; // Mask of fault byte
    localparam logic [ADDR_W-1:0] OFS_MASK_B = 8'h14; // Mask of notifications
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h18; // Control bits
    localparam logic [ADDR_W-1:0] OFS_STAT   = 8'h1c; // Live status

    // Field widths
    localparam int FAULT_W = 5;
    localparam int NOTE_W  = 4;
    localparam int WARN_W  = 3;
    localparam int INFLT_W = 3;
    localparam int CTRL_W  = 2;
    localparam int STAT_W  = 3;

    // Fault summary bits
    localparam int FB_OVERCURRENT = 0;
    localparam int FB_ACTUATOR    = 1;
    localparam int FB_SEQ_PROBLEM = 2;
    localparam int FB_OVERHEAT    = 3;
    localparam int FB_UNDERVOLT   = 4;
    // Notification bits
    localparam int NB_DONE    = 0;
    localparam int NB_REPEAT  = 1;
    localparam int NB_WARNING = 2;
    localparam int NB_ADC_SAT = 3;
    // Warning detail bits
    localparam int WB_DRIVE    = 0;
    localparam int WB_ACCEL    = 1;
    localparam int WB_MEM_TYPE = 2;
    // Input fault detail bits
    localparam int IB_MISSING = 0;
    localparam int IB_MEM     = 1;
    localparam int IB_PWM     = 2;
    // Control and status bits
    localparam int CB_BYPASS = 0;
    localparam int CB_REPEAT = 1;
    localparam int SB_ACTIVE = 0;
    localparam int SB_ALERT  = 1;
    localparam int SB_PIN    = 2;

    // Reset values
    localparam logic [FAULT_W-1:0] MASK_A_RST = 5'h00;
    localparam logic [NOTE_W-1:0]  MASK_B_RST = 4'h0;
    localparam logic [CTRL_W-1:0]  CTRL_RST   = 2'h0;

    // Resonant frequency window
    localparam int FREQ_W = 10;
    localparam logic [FREQ_W-1:0] FREQ_MIN_HZ = 10'h032; // 50 Hz
    localparam logic [FREQ_W-1:0] FREQ_MAX_HZ = 10'h12c; // 300 Hz

    // Playback state
    typedef enum logic {ST_IDLE, ST_DRIVE} play_state_t;
endpackage

// ---- include/flag_bus_if.sv ----
`timescale 1ns/1ps
interface flag_bus_if #(parameter int W = 4);
    logic [W-1:0] set_evt;   // Hardware event pulses
    logic [W-1:0] clr_req;   // Write-one-to-clear strobes
    logic [W-1:0] flags;     // Sticky flags
    modport bank (input set_evt, input clr_req, output flags);
    modport user (output set_evt, output clr_req, input flags);
endinterface

// ---- core/flag_bank.sv ----
`timescale 1ns/1ps
module flag_bank #(
    parameter int W = 4
) (
    input  wire logic ref_clk_in,
    input  wire logic sys_rst_in,
    flag_bus_if.bank  fb
);
    logic [W-1:0] flag_ff;   // Sticky flag storage
    logic [W-1:0] nxt_flag;  // Next flag value

    // One sticky bit per event, set beats clear
    genvar i;
    for (i = 0; i < W; i++) begin : g_bit
        assign nxt_flag[i] = fb.set_evt[i] | (flag_ff[i] & ~fb.clr_req[i]);
    end

    // Flag register
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            flag_ff <= '0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign fb.flags = flag_ff;
endmodule

// ---- core/freq_range_check.sv ----
`timescale 1ns/1ps
module freq_range_check (
    input  wire logic                              ref_clk_in,
    input  wire logic                              sys_rst_in,
    input  wire logic [haptic_diag_pkg::FREQ_W-1:0] freq_hz_in,
    input  wire logic                              freq_valid_in,
    input  wire logic                              bypass_in,
    output logic                                   out_of_range_out
);
    logic range_bad_ff;  // Registered out-of-window pulse
    wire  below;         // Under the lower edge
    wire  above;         // Over the upper edge

    assign below = freq_hz_in < haptic_diag_pkg::FREQ_MIN_HZ;
    assign above = freq_hz_in > haptic_diag_pkg::FREQ_MAX_HZ;

    // Bypass blocks the check entirely, not just the flag
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            range_bad_ff <= 1'b0;
        end else begin
            range_bad_ff <= freq_valid_in & ~bypass_in & (below | above);
        end
    end

    assign out_of_range_out = range_bad_ff;
endmodule

// ---- testbench/host_side_model.sv ----
`timescale 1ns/1ps
// Host end of the alert wire: a pull-up holds it high when released
module host_side_model (
    input  wire logic alert_oe_n_in,  // Low while device pulls low
    input  wire logic alert_out_in,   // Level the device drives
    output logic      alert_wire_out  // Resolved wire level
);
    // Pull-up wins whenever nobody drives, so no stale value remains
    assign alert_wire_out = alert_oe_n_in ? 1'b1 : alert_out_in;
endmodule

// ---- testbench/tb_haptic_event_diagnostics.sv ----
`timescale 1ns/1ps
module tb_haptic_event_diagnostics;
    logic        ref_clk_in, sys_rst_in, psel_in, penable_in, pwrite_in;
    logic [7:0]  paddr_in;                 // Byte address
    logic [31:0] pwdata_in, prdata_out, r; // Bus data
    logic [9:0]  freq_hz_in;               // Resonant frequency
    logic [16:0] ev;                       // Event and playback inputs
    logic        pready_out, pslverr_out, e, host_alert_n_in, host_alert_n_out;
    logic        host_alert_n_oe_n_out, playback_active_out;
    logic        playback_refused_out, repeat_request_out;
    logic        overcurrent_in, impedance_bad_in, bemf_bad_in, overheat_in;
    logic        undervoltage_in, seq_done_in, adc_saturated_in;
    logic        drive_limited_in, accel_limited_in, mem_type_bad_in;
    logic        missing_sequence_in, mem_corrupt_in, pwm_timeout_in;
    logic        seq_restart_in, play_request_in, play_stop_in, freq_valid_in;
    int          n_mismatch, compares, cyc, n_ref; // Counters
    // One vector so a single task can pulse any input
    assign {freq_valid_in, play_stop_in, play_request_in, seq_restart_in,
            pwm_timeout_in, mem_corrupt_in, missing_sequence_in,
            mem_type_bad_in, accel_limited_in, drive_limited_in,
            adc_saturated_in, seq_done_in, undervoltage_in, overheat_in,
            bemf_bad_in, impedance_bad_in, overcurrent_in} = ev;
    haptic_event_diagnostics u_dut (.*);
    host_side_model u_host (.alert_oe_n_in (host_alert_n_oe_n_out),
                            .alert_out_in  (host_alert_n_out),
                            .alert_wire_out(host_alert_n_in));
    // Clock, then reset for six cycles
    initial begin
        ref_clk_in = 0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    // Hang guard well above the few hundred cycles needed
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end
    // Refusal stands one cycle, so count it instead of sampling it late
    always @(posedge ref_clk_in) begin
        if (playback_refused_out === 1'b1) n_ref <= n_ref + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // APB transfer: request held until pready is sampled high at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk_in);
        {psel_in, penable_in, pwrite_in} <= {2'b10, w};
        {paddr_in, pwdata_in} <= {a, d};
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        do @(posedge ref_clk_in); while (pready_out !== 1'b1);
        r = prdata_out;
        e = pslverr_out;
        {psel_in, penable_in} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r, x);
    endtask
    // Pulse one input, then settle on a falling edge
    task automatic pulse(input int i);
        @(posedge ref_clk_in);
        ev[i] <= 1'b1;
        @(posedge ref_clk_in);
        ev[i] <= 1'b0;
        repeat (3) @(negedge ref_clk_in);
    endtask
    task automatic t_fault();
        pulse(14);
        pulse(0);
        chk({31'h0, playback_active_out}, 32'h0);
        chk({31'h0, host_alert_n_in}, 32'h0);
        rd(haptic_diag_pkg::OFS_STAT, 32'h2);
        pulse(14);
        chk({31'h0, playback_active_out}, 32'h0);
        chk(n_ref, 32'h1);
        rd(haptic_diag_pkg::OFS_FAULT, 32'h1);
        apb(1'b1, haptic_diag_pkg::OFS_FAULT, 32'h1);
        rd(haptic_diag_pkg::OFS_FAULT, 32'h0);
        @(negedge ref_clk_in);
        chk({31'h0, host_alert_n_in}, 32'h1);
    endtask
    task automatic t_warn();
        pulse(14);
        pulse(7);
        chk({31'h0, playback_active_out}, 32'h1);
        rd(haptic_diag_pkg::OFS_WARN, 32'h1);
        rd(haptic_diag_pkg::OFS_NOTE, 32'h4);
        pulse(15);
        apb(1'b1, haptic_diag_pkg::OFS_WARN, 32'h1);
        apb(1'b1, haptic_diag_pkg::OFS_NOTE, 32'h4);
        rd(haptic_diag_pkg::OFS_NOTE, 32'h0);
    endtask
    // Repeat request, sequence end and converter saturation notices
    task automatic t_note();
        apb(1'b1, haptic_diag_pkg::OFS_CTRL, 32'h2);
        pulse(14);
        chk({31'h0, repeat_request_out}, 32'h1);
        pulse(13);
        chk({31'h0, repeat_request_out}, 32'h0);
        pulse(5);
        chk({31'h0, playback_active_out}, 32'h0);
        pulse(6);
        rd(haptic_diag_pkg::OFS_NOTE, 32'hb);
        apb(1'b1, haptic_diag_pkg::OFS_NOTE, 32'hf);
        chk(n_ref, 32'h1);
    endtask
    task automatic t_mask();
        apb(1'b1, haptic_diag_pkg::OFS_MASK_A, 32'h1);
        pulse(0);
        chk({31'h0, host_alert_n_in}, 32'h1);
        rd(haptic_diag_pkg::OFS_FAULT, 32'h1);
        apb(1'b1, haptic_diag_pkg::OFS_FAULT, 32'h1);
        apb(1'b1, haptic_diag_pkg::OFS_MASK_A, 32'h0);
    endtask
    // Frequency test; bypass bit given in ctl
    task automatic t_freq(input logic [9:0] f, input logic [31:0] ctl, x);
        apb(1'b1, haptic_diag_pkg::OFS_CTRL, ctl);
        freq_hz_in <= f;
        pulse(16);
        rd(haptic_diag_pkg::OFS_FAULT, x);
        apb(1'b1, haptic_diag_pkg::OFS_FAULT, 32'h1f);
    endtask
    task automatic t_pwm();
        pulse(12);
        rd(haptic_diag_pkg::OFS_FAULT, 32'h4);
        rd(haptic_diag_pkg::OFS_INFLT, 32'h4);
        apb(1'b1, haptic_diag_pkg::OFS_FAULT, 32'h4);
        rd(haptic_diag_pkg::OFS_INFLT, 32'h0);
    endtask
    task automatic end_sim();
        $display("Mismatches %0d of %0d compares", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        {sys_rst_in, psel_in, penable_in, pwrite_in} = 4'h8;
        {paddr_in, pwdata_in, freq_hz_in, ev} = '0;
        repeat (6) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        rd(haptic_diag_pkg::OFS_MASK_B, 32'h0);
        rd(8'h20, 32'h0);
        chk({31'h0, e}, 32'h1);
        t_fault();
        t_warn();
        t_mask();
        t_freq(10'h028, 32'h0, 32'h2);
        t_freq(10'h028, 32'h1, 32'h0);
        t_freq(10'h12c, 32'h0, 32'h0);
        t_freq(10'h12d, 32'h0, 32'h2);
        t_freq(10'h032, 32'h0, 32'h0);
        t_pwm();
        t_note();
        end_sim();
    end
endmodule
